// File: hdl/tdt_defs.vh
// Constants for the time-of-day clock and interval timer block.
// Assumes a single 250 MHz processor clock and a doubleword storage port.
//
// What this block does
// - The time-of-day clock is a 52-bit binary up-counter that wraps at its maximum.
// - The counter advances once per microsecond from a timebase divided from the clock.
// - A store request writes the counter as one doubleword at the named address rounded down to a doubleword boundary; a set loads it.
// - A set is taken only in supervisor state with the console setting enable on.
// - The counter runs in every processor state, stopped and wait included, until power-off.
// - Microdiagnostic tests on the clock or a clock hardware error make the value invalid.
// - The interval timer is the storage word at byte location 80, open to programs.
// - The interval timer is updated in steps of 3.3 milliseconds.
// - Timer width and step give a full cycle of about 15.4 hours.
// - Interval timer updates stop while the processor is stopped and resume on restart.
// - An interval timer update may be skipped when storage is too busy to take it.
`ifndef TDT_DEFS_VH
`define TDT_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TDT_CLK_PERIOD_NS 4
`define TDT_US_NS         1000
`define TDT_USEC_CYC      (`TDT_US_NS / `TDT_CLK_PERIOD_NS)
`define TDT_CNT_ZERO      16'h0000
`define TDT_CNT_ONE       16'h0001
// 3.3 ms held in microseconds
`define TDT_ITMR_STEP_US  3300

// ----------------------------------------------------------------
// Clock format
// ----------------------------------------------------------------
`define TDT_TOD_W         52
`define TDT_DW_W          64
`define TDT_TOD_LSB       12
`define TDT_TOD_ZERO      52'h0000000000000
`define TDT_TOD_ONE       52'h0000000000001
`define TDT_LOW_PAD       12'h000

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
`define TDT_ADDR_W        24
`define TDT_ITMR_ADDR     24'h000050
`define TDT_DW_MASK       24'hfffff8
`define TDT_BE_ALL        8'hff
`define TDT_BE_HIGH       8'hf0
`define TDT_BE_NONE       8'h00
`define TDT_DW_ZERO       64'h0000000000000000
`define TDT_ADDR_ZERO     24'h000000
// 24 counting bits above 8 fraction bits: 2^24 x 3.3 ms is near 15.4 h
`define TDT_ITMR_STEP     32'h00000100
`define TDT_WORD_HI       63:32
`define TDT_WORD_LO       31:0

`endif

// File: hdl/tdt_usec_base.v
// Microsecond timebase: one-cycle tick every USEC_CYC clocks.
// Free running from reset; nothing in the processor can stop it.
`timescale 1ns/1ns
`include "tdt_defs.vh"

module tdt_usec_base #(
  parameter integer USEC_CYC = `TDT_USEC_CYC
) (
  // Clock and reset
  input  wire clock,
  input  wire nrst,
  // Tick out
  output reg  usTick
);

  reg [15:0] divCount;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (!nrst) begin
      divCount <= `TDT_CNT_ZERO;
      usTick   <= 1'b0;
    end else if (divCount == USEC_CYC[15:0] - `TDT_CNT_ONE) begin
      divCount <= `TDT_CNT_ZERO;
      usTick   <= 1'b1;
    end else begin
      divCount <= divCount + `TDT_CNT_ONE;
      usTick   <= 1'b0;
    end
  end

endmodule

// File: hdl/tdt_step_gen.v
// Interval timer step generator: counts microsecond ticks into steps.
// Assumes usTick is a one-cycle pulse and cpuStopped a same-clock level.
`timescale 1ns/1ns
`include "tdt_defs.vh"

module tdt_step_gen #(
  parameter integer STEP_US = `TDT_ITMR_STEP_US
) (
  // Clock and reset
  input  wire clock,
  input  wire nrst,
  // Timebase and processor state
  input  wire usTick,
  input  wire cpuStopped,
  // Step out
  output reg  stepTick
);

  reg [15:0] usCount;

  // ----------------------------------------------------------------
  // Step counter
  // ----------------------------------------------------------------
  // Frozen, not cleared, while stopped so a restart resumes mid-step
  always @(posedge clock) begin
    if (!nrst) begin
      usCount  <= `TDT_CNT_ZERO;
      stepTick <= 1'b0;
    end else if (usTick && !cpuStopped) begin
      if (usCount == STEP_US[15:0] - `TDT_CNT_ONE) begin
        usCount  <= `TDT_CNT_ZERO;
        stepTick <= 1'b1;
      end else begin
        usCount  <= usCount + `TDT_CNT_ONE;
        stepTick <= 1'b0;
      end
    end else begin
      stepTick <= 1'b0;
    end
  end

endmodule

// File: hdl/tdt_timer.v
// Time-of-day clock and interval timer, top level.
// Assumes the instruction logic shares this clock; the console enable is
// asynchronous. Storage answers each request with a one-cycle memAck.
`timescale 1ns/1ns
`include "tdt_defs.vh"

module tdt_timer #(
  parameter integer USEC_CYC = `TDT_USEC_CYC,
  parameter integer STEP_US  = `TDT_ITMR_STEP_US
) (
  // Clock and reset
  input  wire                     clock,
  input  wire                     nrst,
  // Processor state
  input  wire                     supervisor,
  input  wire                     cpuStopped,
  input  wire                     consoleSetEn,
  // Clock health
  input  wire                     diagActive,
  input  wire                     clockError,
  // Set request
  input  wire                     setReq,
  input  wire [`TDT_DW_W-1:0]     setValue,
  output reg                      setDone,
  output reg                      setRefused,
  // Store request
  input  wire                     storeReq,
  input  wire [`TDT_ADDR_W-1:0]   storeAddr,
  output reg                      storeBusy,
  output reg                      storeDone,
  // Status
  output reg                      clockValid,
  output reg  [`TDT_TOD_W-1:0]    todValue,
  output reg                      itmrSkipped,
  // Storage port
  output reg                      memReq,
  output reg                      memWe,
  output reg  [`TDT_ADDR_W-1:0]   memAddr,
  output reg  [7:0]               memBe,
  output reg  [`TDT_DW_W-1:0]     memWdata,
  input  wire [`TDT_DW_W-1:0]     memRdata,
  input  wire                     memAck
);

  // ----------------------------------------------------------------
  // Storage sequencer states
  // ----------------------------------------------------------------
  localparam [3:0] S_IDLE  = 4'b0001;
  localparam [3:0] S_STORE = 4'b0010;
  localparam [3:0] S_RD    = 4'b0100;
  localparam [3:0] S_WR    = 4'b1000;

  reg  [3:0]             state;
  reg  [3:0]             next_state;
  reg                    enMeta;
  reg                    enSync;
  reg                    storePend;
  reg  [`TDT_ADDR_W-1:0] storeAddrHeld;
  reg                    itmrPend;
  wire                   usTick;
  wire                   stepTick;
  wire                   setOk;
  wire                   invalidate;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Clock sits in the upper bits of the stored doubleword, low bits zero
  function [`TDT_DW_W-1:0] todDword;
    input [`TDT_TOD_W-1:0] tod;
    begin
      todDword = {tod, `TDT_LOW_PAD};
    end
  endfunction

  // Stores always land on a doubleword boundary
  function [`TDT_ADDR_W-1:0] dwAlign;
    input [`TDT_ADDR_W-1:0] addr;
    begin
      dwAlign = addr & `TDT_DW_MASK;
    end
  endfunction

  // One step off the timer's counting bits; wraps below zero
  function [31:0] itmrDec;
    input [31:0] word;
    begin
      itmrDec = word - `TDT_ITMR_STEP;
    end
  endfunction

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  tdt_usec_base #(
    .USEC_CYC (USEC_CYC)
  ) uBase (
    .clock  (clock),
    .nrst   (nrst),
    .usTick (usTick)
  );

  tdt_step_gen #(
    .STEP_US (STEP_US)
  ) uStep (
    .clock      (clock),
    .nrst       (nrst),
    .usTick     (usTick),
    .cpuStopped (cpuStopped),
    .stepTick   (stepTick)
  );

  // ----------------------------------------------------------------
  // Console enable synchroniser
  // ----------------------------------------------------------------
  // Console switch is not on this clock: two flops before any use
  always @(posedge clock) begin
    if (!nrst) begin
      enMeta <= 1'b0;
      enSync <= 1'b0;
    end else begin
      enMeta <= consoleSetEn;
      enSync <= enMeta;
    end
  end

  assign setOk      = setReq && supervisor && enSync;
  assign invalidate = diagActive || clockError;

  // ----------------------------------------------------------------
  // Time-of-day counter
  // ----------------------------------------------------------------
  // cpuStopped does not reach this counter: it runs when stopped
  // A set in the same cycle as a microsecond tick wins; that tick is lost
  always @(posedge clock) begin
    if (!nrst) begin
      todValue <= `TDT_TOD_ZERO;
    end else if (setOk) begin
      todValue <= setValue[`TDT_DW_W-1:`TDT_TOD_LSB];
    end else if (usTick) begin
      todValue <= todValue + `TDT_TOD_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Validity and set answers
  // ----------------------------------------------------------------
  // Invalidation beats a set in the same cycle: a failing clock is not trusted
  always @(posedge clock) begin
    if (!nrst) begin
      clockValid <= 1'b0;
      setDone    <= 1'b0;
      setRefused <= 1'b0;
    end else begin
      setDone    <= setOk;
      setRefused <= setReq && !setOk;
      if (invalidate) begin
        clockValid <= 1'b0;
      end else if (setOk) begin
        clockValid <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Store pending
  // ----------------------------------------------------------------
  // A store that arrives while one is pending is ignored, not queued
  always @(posedge clock) begin
    if (!nrst) begin
      storePend     <= 1'b0;
      storeAddrHeld <= `TDT_ADDR_ZERO;
      storeBusy     <= 1'b0;
    end else begin
      if (storeReq && !storePend) begin
        storePend     <= 1'b1;
        storeAddrHeld <= dwAlign(storeAddr);
      end else if (state == S_STORE && memAck) begin
        storePend <= 1'b0;
      end
      storeBusy <= (storeReq && !storePend) ||
                   (storePend && !(state == S_STORE && memAck));
    end
  end

  // ----------------------------------------------------------------
  // Timer step pending
  // ----------------------------------------------------------------
  // A step arriving while the previous one still waits is dropped, so a
  // storage port that is held off loses timer steps rather than queueing
  always @(posedge clock) begin
    if (!nrst) begin
      itmrPend    <= 1'b0;
      itmrSkipped <= 1'b0;
    end else begin
      if (stepTick) begin
        itmrPend <= 1'b1;
      end else if (state == S_WR && memAck) begin
        itmrPend <= 1'b0;
      end
      itmrSkipped <= stepTick && itmrPend;
    end
  end

  // ----------------------------------------------------------------
  // Storage sequencer
  // ----------------------------------------------------------------
  // Store first: the requester waits on it, a timer step may slip
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (storePend) begin
          next_state = S_STORE;
        end else if (itmrPend) begin
          next_state = S_RD;
        end
      end
      S_STORE: begin
        if (memAck) begin
          next_state = S_IDLE;
        end
      end
      S_RD: begin
        if (memAck) begin
          next_state = S_WR;
        end
      end
      S_WR: begin
        if (memAck) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!nrst) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Storage port drive
  // ----------------------------------------------------------------
  // The clock value is sampled when the write is issued, so the stored
  // doubleword is at most one storage wait old
  always @(posedge clock) begin
    if (!nrst) begin
      memReq    <= 1'b0;
      memWe     <= 1'b0;
      memAddr   <= `TDT_ADDR_ZERO;
      memBe     <= `TDT_BE_NONE;
      memWdata  <= `TDT_DW_ZERO;
      storeDone <= 1'b0;
    end else begin
      storeDone <= (state == S_STORE) && memAck;
      case (next_state)
        S_STORE: begin
          if (state != S_STORE) begin
            memReq   <= 1'b1;
            memWe    <= 1'b1;
            memAddr  <= storeAddrHeld;
            memBe    <= `TDT_BE_ALL;
            memWdata <= todDword(todValue);
          end
        end
        S_RD: begin
          if (state != S_RD) begin
            memReq  <= 1'b1;
            memWe   <= 1'b0;
            memAddr <= `TDT_ITMR_ADDR;
            memBe   <= `TDT_BE_HIGH;
          end
        end
        S_WR: begin
          if (state == S_RD) begin
            memReq   <= 1'b1;
            memWe    <= 1'b1;
            memAddr  <= `TDT_ITMR_ADDR;
            memBe    <= `TDT_BE_HIGH;
            memWdata <= {itmrDec(memRdata[`TDT_WORD_HI]),
                         memRdata[`TDT_WORD_LO]};
          end
        end
        S_IDLE: begin
          memReq <= 1'b0;
          memWe  <= 1'b0;
          memBe  <= `TDT_BE_NONE;
        end
        default: begin
          memReq <= 1'b0;
          memWe  <= 1'b0;
        end
      endcase
    end
  end

endmodule

// File: verif/tdt_timer_chk.sv
// Assertion checker for the time-of-day clock and interval timer.
// Sees only the top-level ports; attached by the bind at the foot.
`timescale 1ns/1ns
`include "tdt_defs.vh"

module tdt_timer_chk #(
  parameter integer USEC_CYC = 4
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // Health and set
  input wire logic        diagActive,
  input wire logic        clockError,
  input wire logic [63:0] setValue,
  input wire logic        setDone,
  input wire logic        setRefused,
  // Status
  input wire logic        storeDone,
  input wire logic        clockValid,
  input wire logic [51:0] todValue,
  input wire logic        itmrSkipped,
  // Storage port
  input wire logic        memReq,
  input wire logic        memWe,
  input wire logic [23:0] memAddr,
  input wire logic [7:0]  memBe,
  input wire logic [63:0] memWdata,
  input wire logic [63:0] memRdata,
  input wire logic        memAck
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [31:0] rdHi;
  int          stillCnt;
  always @(posedge clock) begin
    if (!nrst) begin
      rdHi <= 32'h0;
      // Divider restarts with reset: first tick lands one edge later
      stillCnt <= -1;
    end else begin
      if (memAck && !memWe) rdHi <= memRdata[63:32];
      stillCnt <= (todValue != $past(todValue)) ? 0 : stillCnt + 1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  tod_step_a: assert property (todValue != $past(todValue) && !setDone |->
    todValue == $past(todValue) + 52'h1) else $error("clock moved by other than one");
  tod_rate_a: assert property (stillCnt <= USEC_CYC)
    else $error("clock stalled");
  set_load_a: assert property (setDone |-> todValue == $past(setValue[63:12]))
    else $error("set value not loaded");
  refuse_hold_a: assert property (setRefused |-> todValue - $past(todValue) <= 52'h1)
    else $error("refused set changed the clock");
  valid_set_a: assert property (setDone && !$past(diagActive) && !$past(clockError)
    |-> clockValid) else $error("good set left clock invalid");
  invalid_a: assert property (diagActive || clockError |=> !clockValid)
    else $error("clock not invalidated");
  itmr_addr_a: assert property (memReq && memBe == 8'hf0 |-> memAddr == 24'h000050)
    else $error("timer access at wrong address");
  itmr_dec_a: assert property (memReq && memWe && memBe == 8'hf0
    |-> memWdata[63:32] == rdHi - 32'h00000100) else $error("timer not decremented");
  store_pad_a: assert property (memReq && memWe && memBe == 8'hff
    |-> memWdata[11:0] == 12'h000 && memAddr[2:0] == 3'h0) else $error("bad store word");
  mem_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
    else $error("storage request dropped early");
  store_done_a: assert property (storeDone |-> $past(memAck) && $past(memWe))
    else $error("store done without write ack");

  cover property (setRefused);
  cover property (storeDone);
  cover property (itmrSkipped);
endmodule

bind tdt_timer tdt_timer_chk #(.USEC_CYC(USEC_CYC)) chk_u (.*);

// File: verif/tdt_mem_model.sv
// Storage model: holds the timer word and the last clock store.
// Answers each request after lag cycles; data bus churns when idle.
`timescale 1ns/1ns

module tdt_mem_model #(
  parameter logic [63:0] ITMR_INIT = 64'h0001000000000000
) (
  // Clock, reset and answer delay
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [7:0]  lag,
  // Storage port
  input wire logic        memReq,
  input wire logic        memWe,
  input wire logic [23:0] memAddr,
  input wire logic [7:0]  memBe,
  input wire logic [63:0] memWdata,
  output logic     [63:0] memRdata,
  output logic            memAck
);
  logic [63:0] itmrWord;
  logic [63:0] stWr;
  logic [23:0] stAddr;
  int          cnt;
  int          wrCnt;

  always @(posedge clock) begin
    if (!nrst) begin
      memAck <= 1'h0;
      cnt <= 0;
      wrCnt <= 0;
      itmrWord <= ITMR_INIT;
      memRdata <= 64'h0;
    end else if (memAck) begin
      memAck <= 1'h0;
      cnt <= 0;
      memRdata <= ~memRdata;
    end else if (memReq && cnt + 1 >= lag) begin
      memAck <= 1'h1;
      if (!memWe) begin
        memRdata <= itmrWord;
      end else if (memBe == 8'hf0) begin
        itmrWord[63:32] <= memWdata[63:32];
        wrCnt <= wrCnt + 1;
      end else begin
        stWr <= memWdata;
        stAddr <= memAddr;
      end
    end else begin
      cnt <= memReq ? cnt + 1 : 0;
      memRdata <= ~memRdata;
    end
  end
endmodule

// File: verif/tb.sv
// Self-checking bench for the time-of-day clock and interval timer.
// Short counts: 4 cycles a microsecond, 3 microseconds a timer step.
`timescale 1ns/1ns

module tb;
  logic        clock, nrst, supervisor, cpuStopped, consoleSetEn, diagActive, clockError;
  logic        setReq, storeReq, setDone, setRefused, storeBusy, storeDone;
  logic        clockValid, itmrSkipped, memReq, memWe, memAck;
  logic [63:0] setValue, memWdata, memRdata;
  logic [23:0] storeAddr, memAddr;
  logic [7:0]  memBe, lag;
  logic [51:0] todValue, t0;
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          n;

  tdt_timer #(.USEC_CYC(4), .STEP_US(3)) dut_u (.*);
  tdt_mem_model mem_u (.*);

  // ----------------------------------------------------------------
  // Clock, timeout, report
  // ----------------------------------------------------------------
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  task end_sim;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task setPulse(input logic [63:0] v);
    @(posedge clock);
    setReq <= 1'h1;
    setValue <= v;
    @(posedge clock);
    setReq <= 1'h0;
    #1;
  endtask
  task waitChange;
    t0 = todValue;
    repeat (12) begin
      @(posedge clock);
      #1;
      if (todValue !== t0) break;
    end
  endtask
  task settle(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_tick;
    @(posedge clock);
    cpuStopped <= 1'h1;
    waitChange();
    t0 = todValue;
    settle(40);
    chk(todValue, t0 + 52'ha);
    @(posedge clock);
    cpuStopped <= 1'h0;
  endtask
  task t_set;
    setPulse(64'hfffffffffffff000);
    chk(setDone, 1'h1);
    chk(todValue, 52'hfffffffffffff);
    chk(clockValid, 1'h1);
    waitChange();
    chk(todValue, 52'h0);
  endtask
  task t_refuse;
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      supervisor <= i[0];
      consoleSetEn <= ~i[0];
      settle(3);
      setPulse(64'h123456789abcd000);
      chk(setRefused, 1'h1);
      chk(todValue == 52'h123456789abcd, 1'h0);
    end
    @(posedge clock);
    consoleSetEn <= 1'h1;
    settle(3);
  endtask
  task t_invalid;
    for (int i = 0; i < 2; i++) begin
      setPulse(64'h1000);
      chk(clockValid, 1'h1);
      @(posedge clock);
      diagActive <= ~i[0];
      clockError <= i[0];
      @(posedge clock);
      diagActive <= 1'h0;
      clockError <= 1'h0;
      #1;
      chk(clockValid, 1'h0);
      settle(3);
      chk(clockValid, 1'h0);
    end
  endtask
  task t_store;
    @(posedge clock);
    storeReq <= 1'h1;
    storeAddr <= 24'h000123;
    @(posedge clock);
    storeReq <= 1'h0;
    #1;
    chk(storeBusy, 1'h1);
    for (n = 0; n < 100 && storeDone !== 1'h1; n++) settle(1);
    chk(storeDone, 1'h1);
    chk(storeBusy, 1'h0);
    chk(mem_u.stAddr, 24'h000120);
    chk(mem_u.stWr[11:0], 12'h000);
    chk(todValue - mem_u.stWr[63:12] <= 52'h1, 1'h1);
  endtask
  task t_itmr;
    for (n = 0; n < 100 && memReq !== 1'h0; n++) settle(1);
    chk(mem_u.itmrWord[63:32], 32'h00010000 - mem_u.wrCnt * 32'h100);
    chk(mem_u.wrCnt > 0, 1'h1);
    @(posedge clock);
    cpuStopped <= 1'h1;
    settle(40);
    n = mem_u.wrCnt;
    settle(100);
    chk(mem_u.wrCnt, n);
    @(posedge clock);
    cpuStopped <= 1'h0;
    settle(100);
    chk(mem_u.wrCnt > n, 1'h1);
    @(posedge clock);
    lag <= 8'h1e;
    for (n = 0; n < 400 && itmrSkipped !== 1'h1; n++) settle(1);
    chk(itmrSkipped, 1'h1);
    @(posedge clock);
    lag <= 8'h02;
  endtask

  initial begin
    {supervisor, consoleSetEn} = 2'h3;
    {cpuStopped, diagActive, clockError, setReq, storeReq, nrst} = 6'h0;
    setValue = 64'h0;
    storeAddr = 24'h0;
    lag = 8'h02;
    repeat (8) @(posedge clock);
    nrst <= 1'h1;
    settle(4);
    t_tick();
    t_set();
    t_refuse();
    t_invalid();
    t_store();
    t_itmr();
    end_sim();
  end
endmodule
